// >>> rtl/dbc_unit.v
`timescale 1ns/1ns
`include "dbc_consts.vh"

// How it works
// - Byte complement inverts register, writes it back
// - Byte complement: E on 80h, V,C cleared
// - Byte complement: Z on zero, N from bit7
// - Signed word divide: low word by register
// - Signed word divide: V on zero, overflow, listed case
// - Signed long divide of full accumulator
// - Unsigned long divide of full accumulator
// - Long divides: V on zero or overflow
// - Unsigned word divide: low word by register
// - Word divides ignore old high word
// - Z, N from quotient; both cleared on V
// - Divides are two bytes, index repeated
// - Unsigned word divide: V only on zero

module dbc_unit (
  input  wire        clk,          // Core clock, 250 MHz
  input  wire        rst,          // Async reset, active high
  input  wire        opValid,      // Instruction issued, held until taken
  input  wire [7:0]  opcode,       // First instruction byte
  input  wire [7:0]  opSecond,     // Second instruction byte
  input  wire [7:0]  byteOperand,  // Byte register value
  input  wire [15:0] wordOperand,  // Divisor word register value
  input  wire        mdLoadHigh,   // Core writes accumulator high word
  input  wire        mdLoadLow,    // Core writes accumulator low word
  input  wire [15:0] mdLoadData,   // Data for accumulator writes
  output reg         opReady_ff,   // Idle, may take an instruction
  output reg         opDone_ff,    // Instruction finished, pulse
  output reg         opIllegal_ff, // Bad encoding rejected, pulse
  output reg  [7:0]  byteResult_ff,// Complemented byte
  output reg         byteWrite_ff, // Write byteResult back, pulse
  output reg         flagE_ff,     // End-of-table flag
  output reg         flagZ_ff,     // Zero flag
  output reg         flagV_ff,     // Overflow flag
  output reg         flagC_ff,     // Carry flag
  output reg         flagN_ff,     // Negative flag
  output reg  [15:0] mdHigh_ff,    // Accumulator high word
  output reg  [15:0] mdLow_ff      // Accumulator low word
);

  // Sequencer states: idle or divide in flight
  localparam ST_IDLE = 1'b0;
  localparam ST_DIV  = 1'b1;

  // Operand signs and mode, captured when a divide starts
  reg         state_ff;
  reg         isSigned_ff;
  reg         isLong_ff;
  reg         negQuot_ff;
  reg         negRem_ff;
  reg         listedOvf_ff;

  // Two's complement magnitude of a value taken as signed
  function [31:0] magnitude32;
    input [31:0] val;
    input        sgn;
    begin
      magnitude32 = (sgn && val[31]) ? (~val + 32'h00000001) : val;
    end
  endfunction

  // Divide opcodes share the two-byte format
  function isDivide;
    input [7:0] op;
    begin
      isDivide = (op == `DBC_OP_DIV) || (op == `DBC_OP_UDIV_W) ||
                 (op == `DBC_OP_SDIV_L) || (op == `DBC_OP_UDIV_L);
    end
  endfunction

  // Decode of the taken instruction
  // Bad encodings fall through to the illegal pulse
  wire        take      = opValid && opReady_ff;
  wire        opCpl     = (opcode == `DBC_OP_BYTE_CPL);
  wire        opDiv     = isDivide(opcode);
  wire        cplOk     = opCpl && (opSecond[3:0] == 4'h0);
  wire        divOk     = opDiv && (opSecond[7:4] == opSecond[3:0]);
  wire        sgnOp     = (opcode == `DBC_OP_DIV) ||
                          (opcode == `DBC_OP_SDIV_L);
  wire        longOp    = (opcode == `DBC_OP_SDIV_L) ||
                          (opcode == `DBC_OP_UDIV_L);
  wire        zeroDvs   = (wordOperand == 16'h0000);
  wire [7:0]  cplVal    = ~byteOperand;

  // Dividend: full accumulator for long forms, low word only else
  wire [31:0] dvdLong   = {mdHigh_ff, mdLow_ff};
  wire [31:0] dvdWord   = sgnOp ? {{16{mdLow_ff[15]}}, mdLow_ff}
                                : {16'h0000, mdLow_ff};
  wire [31:0] dvdRaw    = longOp ? dvdLong : dvdWord;
  wire [31:0] dvsRaw    = {{16{wordOperand[15]}}, wordOperand};
  wire [31:0] dvdMag    = magnitude32(dvdRaw, sgnOp);
  wire [31:0] dvsMag    = magnitude32(dvsRaw, sgnOp);
  wire        divStart  = take && divOk && !zeroDvs;

  // Raw unsigned results of the divider core
  wire        divDone;
  wire [31:0] quotMag;
  wire [15:0] remMag;

  // Unsigned core; signs are restored around it
  dbc_divider #(
    .STEPS    (`DBC_DIV_STEPS)
  ) uDivider (
    .clk      (clk),
    .rst      (rst),
    .start    (divStart),
    .dividend (dvdMag),
    .divisor  (dvsMag[15:0]),
    .done_ff  (divDone),
    .quot_ff  (quotMag),
    .rem_ff   (remMag)
  );

  // Sign fixup and word-range test of the quotient
  wire [31:0] quotFix   = negQuot_ff ? (~quotMag + 32'h00000001) : quotMag;
  wire [15:0] remFix    = negRem_ff ? (~remMag + 16'h0001) : remMag;
  wire        sgnRange  = negQuot_ff ? (quotMag > `DBC_SQ_NEG)
                                     : (quotMag > `DBC_SQ_POS);
  wire        unsRange  = (quotMag[31:16] != 16'h0000);
  wire        nxt_ovf   = listedOvf_ff ||
                          (isSigned_ff ? sgnRange : unsRange);
  wire [15:0] nxt_quot  = quotFix[15:0];

  // Sequencer, flags and accumulator
  // Loads are refused while busy so a divide never sees a torn dividend
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff      <= ST_IDLE;
      isSigned_ff   <= 1'b0;
      isLong_ff     <= 1'b0;
      negQuot_ff    <= 1'b0;
      negRem_ff     <= 1'b0;
      listedOvf_ff  <= 1'b0;
      opReady_ff    <= 1'b0;
      opDone_ff     <= 1'b0;
      opIllegal_ff  <= 1'b0;
      byteResult_ff <= 8'h00;
      byteWrite_ff  <= 1'b0;
      flagE_ff      <= 1'b0;
      flagZ_ff      <= 1'b0;
      flagV_ff      <= 1'b0;
      flagC_ff      <= 1'b0;
      flagN_ff      <= 1'b0;
      mdHigh_ff     <= `DBC_ACC_RESET;
      mdLow_ff      <= `DBC_ACC_RESET;
    end else begin
      opDone_ff    <= 1'b0;
      opIllegal_ff <= 1'b0;
      byteWrite_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          opReady_ff <= 1'b1;
          // Core writes to the accumulator only land while idle
          if (mdLoadHigh) begin
            mdHigh_ff <= mdLoadData;
          end
          if (mdLoadLow) begin
            mdLow_ff <= mdLoadData;
          end
          if (take && cplOk) begin
            byteResult_ff <= cplVal;
            byteWrite_ff  <= 1'b1;
            opDone_ff     <= 1'b1;
            flagE_ff      <= (byteOperand == `DBC_BYTE_MIN);
            flagV_ff      <= 1'b0;
            flagC_ff      <= 1'b0;
            flagZ_ff      <= (cplVal == 8'h00);
            flagN_ff      <= cplVal[7];
          end else if (take && divOk && zeroDvs) begin
            // Zero divisor finishes at once, accumulator kept
            opDone_ff <= 1'b1;
            flagV_ff  <= 1'b1;
            flagE_ff  <= 1'b0;
            flagC_ff  <= 1'b0;
            flagZ_ff  <= 1'b0;
            flagN_ff  <= 1'b0;
          end else if (divStart) begin
            state_ff     <= ST_DIV;
            opReady_ff   <= 1'b0;
            isSigned_ff  <= sgnOp;
            isLong_ff    <= longOp;
            negQuot_ff   <= sgnOp && (dvdRaw[31] != wordOperand[15]);
            negRem_ff    <= sgnOp && dvdRaw[31];
            // Word signed form also flags the listed operand pair
            listedOvf_ff <= (opcode == `DBC_OP_DIV) &&
                            (mdLow_ff == `DBC_OVF_DVD) &&
                            (wordOperand == `DBC_OVF_DVS);
          end else if (take) begin
            opIllegal_ff <= 1'b1;
          end
        end
        ST_DIV: begin
          opReady_ff <= 1'b0;
          if (divDone) begin
            state_ff   <= ST_IDLE;
            opReady_ff <= 1'b1;
            opDone_ff  <= 1'b1;
            flagV_ff   <= nxt_ovf;
            flagE_ff   <= 1'b0;
            flagC_ff   <= 1'b0;
            // Overflowed results are not stored; Z, N then read zero
            flagZ_ff   <= !nxt_ovf && (nxt_quot == 16'h0000);
            flagN_ff   <= !nxt_ovf && nxt_quot[15];
            if (!nxt_ovf) begin
              mdLow_ff  <= nxt_quot;
              mdHigh_ff <= remFix;
            end
          end
        end
        default: begin
          state_ff   <= ST_IDLE;
          opReady_ff <= 1'b0;
        end
      endcase
    end
  end

endmodule

// >>> rtl/dbc_consts.vh
`ifndef DBC_CONSTS_VH
`define DBC_CONSTS_VH

// First-byte opcodes of the handled instructions
`define DBC_OP_BYTE_CPL 8'hb1
`define DBC_OP_DIV      8'h4b
`define DBC_OP_UDIV_W   8'h5b
`define DBC_OP_SDIV_L   8'h6b
`define DBC_OP_UDIV_L   8'h7b

// Most negative byte value, raises the end-of-table flag
`define DBC_BYTE_MIN  8'h80

// Listed unrepresentable signed 16-by-16 operand pair
`define DBC_OVF_DVD   16'h8000
`define DBC_OVF_DVS   16'hfffe

// Largest quotient magnitudes that fit a word
`define DBC_SQ_POS    32'h00007fff
`define DBC_SQ_NEG    32'h00008000

// Divider iterations, one quotient bit per clock
`define DBC_DIV_STEPS 32

// Accumulator reset value
`define DBC_ACC_RESET 16'h0000

`endif

// >>> rtl/dbc_divider.v
`timescale 1ns/1ns
`include "dbc_consts.vh"

module dbc_divider #(
  parameter STEPS = `DBC_DIV_STEPS
) (
  input  wire        clk,       // Core clock
  input  wire        rst,       // Async reset, active high
  input  wire        start,     // Load operands, one-cycle pulse
  input  wire [31:0] dividend,  // Unsigned dividend
  input  wire [15:0] divisor,   // Unsigned divisor, never zero
  output reg         done_ff,   // Result valid, one-cycle pulse
  output reg  [31:0] quot_ff,   // Quotient
  output reg  [15:0] rem_ff     // Remainder
);

  reg  [5:0]  cnt_ff;
  reg  [15:0] divisor_ff;
  wire [16:0] shifted;
  wire [16:0] diff;

  // Restoring step: trial subtract of the shifted partial remainder
  assign shifted = {rem_ff, quot_ff[31]};
  assign diff    = shifted - {1'b0, divisor_ff};

  // One bit per cycle keeps the adder at 17 bits at 250 MHz
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff     <= 6'h00;
      divisor_ff <= 16'h0000;
      quot_ff    <= 32'h00000000;
      rem_ff     <= 16'h0000;
      done_ff    <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start) begin
        cnt_ff     <= STEPS[5:0];
        divisor_ff <= divisor;
        quot_ff    <= dividend;
        rem_ff     <= 16'h0000;
      end else if (cnt_ff != 6'h00) begin
        cnt_ff <= cnt_ff - 6'h01;
        done_ff <= (cnt_ff == 6'h01);
        if (!diff[16]) begin
          rem_ff  <= diff[15:0];
          quot_ff <= {quot_ff[30:0], 1'b1};
        end else begin
          rem_ff  <= shifted[15:0];
          quot_ff <= {quot_ff[30:0], 1'b0};
        end
      end
    end
  end

endmodule

// >>> tb/dbc_core_model.sv
`timescale 1ns/1ns
// Issuing side of the core
module dbc_core_model (
  input  logic        clk,         // Clock
  input  logic        opReady_ff,  // Unit idle
  output logic        opValid,     // Issue
  output logic [7:0]  opcode,      // Byte one
  output logic [7:0]  opSecond,    // Byte two
  output logic [7:0]  byteOperand, // Byte reg
  output logic [15:0] wordOperand, // Divisor
  output logic        mdLoadHigh,  // Load high
  output logic        mdLoadLow,   // Load low
  output logic [15:0] mdLoadData   // Load data
);
  initial {opValid, opcode, opSecond, byteOperand, wordOperand} = '0;
  initial {mdLoadHigh, mdLoadLow, mdLoadData} = '0;
  // Both bytes held until the taking edge
  task issue(input logic [7:0] o, s, b, input logic [15:0] w);
    {opValid, opcode, opSecond, byteOperand, wordOperand} <= {1'b1, o, s, b, w};
    @(posedge clk);
    while (!opReady_ff) @(posedge clk);
  endtask
  // Released lines inverted so stale values never look valid
  task idle();
    opValid <= 1'b0;
    {opcode, opSecond, byteOperand} <= ~{opcode, opSecond, byteOperand};
    wordOperand <= ~wordOperand;
    @(posedge clk);
  endtask
  task load(input logic h, l, input logic [15:0] d);
    {mdLoadHigh, mdLoadLow, mdLoadData} <= {h, l, d};
    @(posedge clk);
    while (!opReady_ff) @(posedge clk);
    {mdLoadHigh, mdLoadLow, mdLoadData} <= {2'b00, ~d};
    @(posedge clk);
  endtask
endmodule

// >>> tb/dbc_unit_checker.sv
`timescale 1ns/1ns
module dbc_unit_checker (
  input logic clk, rst, opValid, opReady_ff, opDone_ff, opIllegal_ff,
  input logic byteWrite_ff, flagE_ff, flagZ_ff, flagV_ff, flagC_ff,
  input logic flagN_ff, mdLoadHigh, mdLoadLow,
  input logic [7:0] opcode, opSecond, byteOperand, byteResult_ff,
  input logic [15:0] wordOperand, mdHigh_ff, mdLow_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Decoded issues
  wire take = opValid && opReady_ff;
  wire cpl = take && opcode == 8'hb1;
  wire div = take && opcode[3:0] == 4'hb && opcode[7:6] == 2'b01
             && opSecond[7:4] == opSecond[3:0];
  chk_cpl_value: assert property (cpl && opSecond[3:0] == 4'h0 |=>
    byteWrite_ff && byteResult_ff == ~$past(byteOperand)) else $error("cpl");
  chk_cpl_bad: assert property (cpl && opSecond[3:0] != 4'h0 |=>
    opIllegal_ff && !opDone_ff) else $error("encoding");
  chk_cpl_flags: assert property (cpl && opSecond[3:0] == 4'h0 |=>
    flagE_ff == ($past(byteOperand) == 8'h80) && !flagV_ff && !flagC_ff)
    else $error("cpl evc");
  chk_cpl_zn: assert property (byteWrite_ff |->
    flagZ_ff == (byteResult_ff == 8'h00) && flagN_ff == byteResult_ff[7])
    else $error("cpl zn");
  chk_div_time: assert property (div && wordOperand != 16'h0 |=>
    !opReady_ff ##33 opDone_ff && opReady_ff) else $error("latency");
  chk_div_zero: assert property (div && wordOperand == 16'h0 &&
    !mdLoadHigh && !mdLoadLow |=> opDone_ff && flagV_ff &&
    $stable(mdLow_ff) && $stable(mdHigh_ff)) else $error("zero div");
  chk_div_ec: assert property (opDone_ff && !byteWrite_ff |->
    !flagE_ff && !flagC_ff) else $error("div ec");
  chk_ovf_zn: assert property (opDone_ff && flagV_ff |->
    !flagZ_ff && !flagN_ff) else $error("ovf zn");
  chk_acc_pair: assert property (!$past(opReady_ff) && ($changed(mdLow_ff) ||
    $changed(mdHigh_ff)) |-> opDone_ff) else $error("acc split");
endmodule
bind dbc_unit dbc_unit_checker chk (.*);

// >>> tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic        clk = 1'b0, rst = 1'b1;
  logic        opValid, mdLoadHigh, mdLoadLow, opReady_ff, opDone_ff;
  logic        opIllegal_ff, byteWrite_ff, flagE_ff, flagZ_ff, flagV_ff;
  logic        flagC_ff, flagN_ff;
  logic [7:0]  opcode, opSecond, byteOperand, byteResult_ff, br = 8'h00;
  logic [15:0] wordOperand, mdLoadData, mdHigh_ff, mdLow_ff;
  logic [31:0] acc = 32'h0;
  logic [4:0]  flg = 5'h00;
  logic [45:0] notes[$];
  int          n_mismatch = 0, num_checks = 0;
  wire  [45:0] got = {opIllegal_ff, flagE_ff, flagZ_ff, flagV_ff, flagC_ff,
                      flagN_ff, mdHigh_ff, mdLow_ff, byteResult_ff};
  dbc_unit dut (.*);
  dbc_core_model core (.*);
  always #2 clk = ~clk;
  // Reference result noted first, then the core issues
  task automatic op(input logic [7:0] o, s, b, input logic [15:0] w);
    logic [31:0] d;
    logic signed [32:0] q, r;
    logic sg, v, ill;
    sg = o == 8'h4b || o == 8'h6b;
    ill = !(o == 8'hb1 && s[3:0] == 4'h0) && !(o[3:0] == 4'hb &&
          o[7:6] == 2'b01 && s[7:4] == s[3:0]);
    d = o[5] ? acc : {sg ? {16{acc[15]}} : 16'h0, acc[15:0]};
    if (sg) begin
      q = $signed(d) / $signed(w);
      r = $signed(d) % $signed(w);
    end else begin
      q = d / w;
      r = d % w;
    end
    v = w == 16'h0 || (sg ? q > 32767 || q < -32768 : q > 65535) ||
        (o == 8'h4b && acc[15:0] == 16'h8000 && w == 16'hfffe);
    if (!ill && o == 8'hb1) begin
      br = ~b;
      flg = {b == 8'h80, br == 8'h00, 2'b00, br[7]};
    end else if (!ill && v) flg = 5'b00100;
    else if (!ill) begin
      acc = {r[15:0], q[15:0]};
      flg = {1'b0, q[15:0] == 16'h0, 2'b00, q[15]};
    end
    notes.push_back({ill, flg, acc, br});
    core.issue(o, s, b, w);
  endtask
  task ld(input logic [15:0] h, l);
    acc = {h, l};
    core.idle();
    core.load(1'b1, 1'b0, h);
    core.load(1'b0, 1'b1, l);
  endtask
  task stop_test();
    if (n_mismatch == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Results return in issue order
  always @(posedge clk) begin
    if (!rst && (opDone_ff || opIllegal_ff)) begin
      num_checks++;
      if (notes.size() == 0 || got !== notes[0]) begin
        n_mismatch++;
        $display("[ERR] %0t result %h", $time, got);
      end
      if (notes.size() != 0) void'(notes.pop_front());
    end
  end
  initial begin
    #100000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    logic [7:0] t[5] = '{8'hb1, 8'h4b, 8'h5b, 8'h6b, 8'h7b};
    logic [55:0] dv[7] = '{{8'h4b, 16'hffff, 16'h8000, 16'hfffe},
      {8'h4b, 16'h0, 16'h8000, 16'hffff}, {8'h5b, 16'hffff, 16'h64, 16'h7},
      {8'h6b, 16'h7fff, 16'h7fff, 16'h2}, {8'h6b, 16'hffff, 16'hfff0, 16'h3},
      {8'h7b, 16'hffff, 16'h0, 16'h1}, {8'h7b, 16'h1, 16'h0, 16'h2}};
    logic [3:0] n;
    void'($urandom(32'h4a3f));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    op(8'hb1, 8'h30, 8'h80, 16'h0);
    op(8'hb1, 8'h50, 8'hff, 16'h0);
    op(8'hb1, 8'h05, 8'h12, 16'h0);
    op(8'h00, 8'h00, 8'h00, 16'h0);
    op(8'h4b, 8'h12, 8'h00, 16'h5);
    ld(16'h1234, 16'h5678);
    for (int i = 1; i < 5; i++) op(t[i], 8'h55, 8'h0, 16'h0);
    foreach (dv[i]) begin
      ld(dv[i][47:32], dv[i][31:16]);
      op(dv[i][55:48], 8'h22, 8'h0, dv[i][15:0]);
    end
    repeat (40) begin
      ld(16'($urandom) >> $urandom_range(16), 16'($urandom));
      n = 4'($urandom);
      op(t[$urandom_range(4)], 8'h00, 8'($urandom), 16'($urandom));
      op(t[$urandom_range(4)], {n, n}, 8'($urandom), 16'($urandom));
    end
    core.idle();
    repeat (40) @(posedge clk);
    if (notes.size() != 0) n_mismatch++;
    stop_test();
  end
endmodule
